/* src/twr_pkg.sv */
// Shared constants, types and state layout of the two-wire register access port.
package twr_pkg;

  // ----------------------------------------------------------------------
  // Sizes and field positions
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int HOLD_BIT = 7;
  localparam int SYNC_STAGES = 2;
  localparam int SYNC_W = 6;
  localparam int SCL_BIT = 0;
  localparam int SDA_BIT = 1;
  localparam int STRAP_LSB = 2;
  localparam int STRAP_W = 4;

  // ----------------------------------------------------------------------
  // Values and counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [6:0] PTR_MAX = 7'h7F;
  localparam logic [6:0] PTR_STEP = 7'h01;
  localparam logic [2:0] ADDR_HI = 3'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [1:0] STRAP_DLY = 2'h3;
  localparam logic [1:0] CAP_STEP = 2'h1;
  // Reset hold that the system applies before release, in milliseconds.
  localparam int RESET_HOLD_MS = 100;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [7:0] {
    TWR_IDLE     = 8'h01,
    TWR_ADDR     = 8'h02,
    TWR_ACK_ADDR = 8'h04,
    TWR_WRITE    = 8'h08,
    TWR_ACK_WR   = 8'h10,
    TWR_READ     = 8'h20,
    TWR_ACK_RD   = 8'h40,
    TWR_IGNORE   = 8'h80
  } twr_state_e;

  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } twr_wr_s;

  typedef struct packed {
    twr_state_e state;
    logic [7:0] ptr;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [3:0] bitcnt;
    logic rw;
    logic first;
    logic addressed;
    logic nack;
    logic scl_prev;
    logic sda_prev;
    logic [6:0] slave_addr;
    logic [1:0] cap_cnt;
    logic captured;
    logic sda_oe_n;
    logic sda_lvl;
    twr_wr_s wr;
  } twr_state_s;

  localparam twr_state_s STATE_RESET = '{
    state: TWR_IDLE, ptr: 8'h00, shift: 8'h00, tx: 8'h00, bitcnt: 4'h0,
    rw: 1'b0, first: 1'b0, addressed: 1'b0, nack: 1'b0, scl_prev: 1'b1,
    sda_prev: 1'b1, slave_addr: 7'h00, cap_cnt: 2'h0, captured: 1'b0,
    sda_oe_n: 1'b1, sda_lvl: 1'b0, wr: '{en: 1'b0, addr: 7'h00, data: 8'h00}
  };

endpackage : twr_pkg

/* src/twr_sync.sv */
// Two-flop synchroniser for the serial pins and address straps.
`timescale 1ns/1ns
module twr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : twr_sync

/* src/twr_reg_mem.sv */
// Byte register file with one write port and a registered read port.
`timescale 1ns/1ns
module twr_reg_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input twr_pkg::twr_wr_s wr_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge clock_i) begin
    if (wr_i.en) begin
      mem_q[wr_i.addr] <= wr_i.data;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule : twr_reg_mem

/* src/twr_port.sv */
// Two-wire slave port giving a host access to 128 byte registers.
`timescale 1ns/1ns
module twr_port (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic primary_serial_clock_i,
  input wire logic primary_serial_data_i,
  input wire logic [twr_pkg::STRAP_W-1:0] addr_strap_i,
  output logic primary_serial_data_o,
  output logic primary_serial_data_oe_n_o,
  output logic [twr_pkg::ADDR_W-1:0] slave_addr_o,
  output twr_pkg::twr_wr_s reg_wr_o
);

  // ----------------------------------------------------------------------
  // Pin synchronisation and bus conditions
  // ----------------------------------------------------------------------
  logic [twr_pkg::SYNC_W-1:0] sync_s;
  logic scl_s;
  logic sda_s;
  logic [twr_pkg::STRAP_W-1:0] strap_s;
  logic [twr_pkg::DATA_W-1:0] rdata;
  twr_pkg::twr_state_s q;
  twr_pkg::twr_state_s d;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic ptr_load;

  twr_sync #(
    .W(twr_pkg::SYNC_W),
    .RST_VAL({twr_pkg::SYNC_W{1'b1}})
  ) u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i({addr_strap_i, primary_serial_data_i, primary_serial_clock_i}),
    .sync_o(sync_s)
  );

  assign scl_s = sync_s[twr_pkg::SCL_BIT];
  assign sda_s = sync_s[twr_pkg::SDA_BIT];
  assign strap_s = sync_s[twr_pkg::STRAP_LSB +: twr_pkg::STRAP_W];
  assign rise = scl_s && !q.scl_prev;
  assign fall = !scl_s && q.scl_prev;
  assign start_det = scl_s && q.scl_prev && q.sda_prev && !sda_s;
  assign stop_det = scl_s && q.scl_prev && !q.sda_prev && sda_s;
  assign ptr_load = (q.state == twr_pkg::TWR_WRITE) && fall && q.first &&
                    (q.bitcnt == twr_pkg::BITS_PER_BYTE);

  twr_reg_mem #(
    .AW(twr_pkg::ADDR_W),
    .DW(twr_pkg::DATA_W)
  ) u_mem (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_i(q.wr),
    .raddr_i(q.ptr[twr_pkg::ADDR_W-1:0]),
    .rdata_o(rdata)
  );

  // ----------------------------------------------------------------------
  // Pointer advance: held by the hold flag, saturating at the top register.
  // ----------------------------------------------------------------------
  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    if (p[twr_pkg::HOLD_BIT] || (p[6:0] == twr_pkg::PTR_MAX)) begin
      return p;
    end
    return {p[twr_pkg::HOLD_BIT], p[6:0] + twr_pkg::PTR_STEP};
  endfunction : next_ptr

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    d.wr.en = 1'b0;
    d.scl_prev = scl_s;
    d.sda_prev = sda_s;
    // The synchroniser needs a few cycles after release before straps are valid.
    if (!q.captured) begin
      if (q.cap_cnt == twr_pkg::STRAP_DLY) begin
        d.slave_addr = {twr_pkg::ADDR_HI, strap_s};
        d.captured = 1'b1;
      end else begin
        d.cap_cnt = q.cap_cnt + twr_pkg::CAP_STEP;
      end
    end
    if (stop_det) begin
      if (q.addressed) begin
        d.ptr = twr_pkg::PTR_RESET;
      end
      d.state = twr_pkg::TWR_IDLE;
      d.addressed = 1'b0;
      d.sda_oe_n = 1'b1;
    end else if (start_det && q.captured) begin
      // The pointer is deliberately left alone here.
      d.state = twr_pkg::TWR_ADDR;
      d.bitcnt = '0;
      d.sda_oe_n = 1'b1;
    end else begin
      case (q.state)
        twr_pkg::TWR_ADDR: begin
          if (rise) begin
            d.shift = {q.shift[6:0], sda_s};
            d.bitcnt = q.bitcnt + twr_pkg::BIT_STEP;
          end else if (fall && (q.bitcnt == twr_pkg::BITS_PER_BYTE)) begin
            if (q.shift[7:1] == q.slave_addr) begin
              d.state = twr_pkg::TWR_ACK_ADDR;
              d.sda_oe_n = 1'b0;
              d.rw = q.shift[0];
              d.addressed = 1'b1;
              d.first = 1'b1;
            end else begin
              d.state = twr_pkg::TWR_IGNORE;
            end
          end
        end
        twr_pkg::TWR_ACK_ADDR: begin
          if (fall) begin
            d.bitcnt = '0;
            if (q.rw) begin
              d.state = twr_pkg::TWR_READ;
              d.tx = rdata;
              d.sda_oe_n = rdata[7];
            end else begin
              d.state = twr_pkg::TWR_WRITE;
              d.sda_oe_n = 1'b1;
            end
          end
        end
        twr_pkg::TWR_WRITE: begin
          if (rise) begin
            d.shift = {q.shift[6:0], sda_s};
            d.bitcnt = q.bitcnt + twr_pkg::BIT_STEP;
          end else if (fall && (q.bitcnt == twr_pkg::BITS_PER_BYTE)) begin
            if (q.first) begin
              d.ptr = q.shift;
              d.first = 1'b0;
            end else begin
              d.wr.en = 1'b1;
              d.wr.addr = q.ptr[6:0];
              d.wr.data = q.shift;
              d.ptr = next_ptr(q.ptr);
            end
            d.state = twr_pkg::TWR_ACK_WR;
            d.sda_oe_n = 1'b0;
          end
        end
        twr_pkg::TWR_ACK_WR: begin
          if (fall) begin
            d.state = twr_pkg::TWR_WRITE;
            d.bitcnt = '0;
            d.sda_oe_n = 1'b1;
          end
        end
        twr_pkg::TWR_READ: begin
          if (fall) begin
            d.bitcnt = q.bitcnt + twr_pkg::BIT_STEP;
            if (q.bitcnt == twr_pkg::LAST_BIT) begin
              d.state = twr_pkg::TWR_ACK_RD;
              d.sda_oe_n = 1'b1;
            end else begin
              d.tx = {q.tx[6:0], 1'b0};
              d.sda_oe_n = q.tx[6];
            end
          end
        end
        twr_pkg::TWR_ACK_RD: begin
          if (rise) begin
            d.nack = sda_s;
            // Advancing on the acknowledge leaves half a bit for the memory read.
            if (!sda_s) begin
              d.ptr = next_ptr(q.ptr);
            end
          end else if (fall) begin
            if (q.nack) begin
              d.state = twr_pkg::TWR_IGNORE;
              d.sda_oe_n = 1'b1;
            end else begin
              d.state = twr_pkg::TWR_READ;
              d.bitcnt = '0;
              d.tx = rdata;
              d.sda_oe_n = rdata[7];
            end
          end
        end
        twr_pkg::TWR_IDLE,
        twr_pkg::TWR_IGNORE: begin
          d.sda_oe_n = 1'b1;
        end
        default: begin
          d.state = twr_pkg::TWR_IDLE;
          d.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= twr_pkg::STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign primary_serial_data_o = q.sda_lvl;
  assign primary_serial_data_oe_n_o = q.sda_oe_n;
  assign slave_addr_o = q.slave_addr;
  assign reg_wr_o = q.wr;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // Pointer handling.
  chk_stop_clear_ptr: assert property (
    stop_det && q.addressed |=> q.ptr == twr_pkg::PTR_RESET)
    else $error("pointer not cleared by stop");
  chk_start_keep_ptr: assert property (start_det |=> $stable(q.ptr))
    else $error("pointer changed on start");
  chk_first_loads_ptr: assert property (ptr_load |=> q.ptr == $past(q.shift))
    else $error("first byte did not load pointer");
  chk_hold_keeps_ptr: assert property (
    q.ptr[twr_pkg::HOLD_BIT] && !stop_det && !ptr_load |=> $stable(q.ptr))
    else $error("held pointer moved");
  chk_top_saturates: assert property (
    (q.ptr[6:0] == twr_pkg::PTR_MAX) && !stop_det && !ptr_load
    |=> q.ptr[6:0] == twr_pkg::PTR_MAX)
    else $error("pointer passed top register");
  chk_write_advance: assert property (
    q.wr.en && !$past(q.ptr[twr_pkg::HOLD_BIT]) && ($past(q.ptr[6:0]) != twr_pkg::PTR_MAX)
    |-> q.ptr[6:0] == $past(q.ptr[6:0]) + twr_pkg::PTR_STEP)
    else $error("pointer did not advance after a write");
  chk_read_advance: assert property (
    q.state == twr_pkg::TWR_ACK_RD && rise && !sda_s && !q.ptr[twr_pkg::HOLD_BIT] &&
    (q.ptr[6:0] != twr_pkg::PTR_MAX)
    |=> q.ptr[6:0] == $past(q.ptr[6:0]) + twr_pkg::PTR_STEP)
    else $error("pointer did not advance after a read");
  chk_write_at_ptr: assert property (q.wr.en |-> q.wr.addr == $past(q.ptr[6:0]))
    else $error("write went to wrong register");

  // Address capture and direction.
  chk_strap_capture: assert property (
    q.captured && !$past(q.captured) |-> q.slave_addr == {twr_pkg::ADDR_HI, $past(strap_s)})
    else $error("strap capture wrong");
  chk_addr_held: assert property (q.captured |=> $stable(q.slave_addr))
    else $error("slave address changed after capture");
  chk_addr_top_zero: assert property (
    q.captured |-> (q.slave_addr >> twr_pkg::STRAP_W) == 7'(twr_pkg::ADDR_HI))
    else $error("upper address bits not zero");
  chk_dir_select: assert property (
    q.state == twr_pkg::TWR_READ && $past(q.state) == twr_pkg::TWR_ACK_ADDR |-> q.rw)
    else $error("read entered on write direction");
  chk_foreign_ignored: assert property (
    q.state == twr_pkg::TWR_ADDR && fall && (q.bitcnt == twr_pkg::BITS_PER_BYTE) &&
    (q.shift[7:1] != q.slave_addr) |=> q.state == twr_pkg::TWR_IGNORE)
    else $error("foreign address not ignored");

  // Data line behaviour.
  chk_ack_addr_low: assert property (q.state == twr_pkg::TWR_ACK_ADDR |-> !q.sda_oe_n)
    else $error("address not acknowledged");
  chk_ack_write_low: assert property (q.state == twr_pkg::TWR_ACK_WR |-> !q.sda_oe_n)
    else $error("written byte not acknowledged");
  chk_host_ack_free: assert property (q.state == twr_pkg::TWR_ACK_RD |-> q.sda_oe_n)
    else $error("data line held during host acknowledge");
  chk_ignore_quiet: assert property (
    q.state == twr_pkg::TWR_IGNORE |-> q.sda_oe_n && !q.wr.en)
    else $error("ignored transfer touched bus");
  chk_read_msb_out: assert property (
    q.state == twr_pkg::TWR_READ |-> q.sda_oe_n == q.tx[7])
    else $error("read bit order wrong");

  // Main scenarios: a written byte, a continued read, an ignored address, a clearing stop
  // and a write at the top register.
  cov_write_byte: cover property (q.wr.en);
  cov_read_ack: cover property (q.state == twr_pkg::TWR_ACK_RD ##1 q.state == twr_pkg::TWR_READ);
  cov_ignore: cover property (q.state == twr_pkg::TWR_IGNORE);
  cov_stop_clear: cover property (stop_det && q.addressed && q.ptr != twr_pkg::PTR_RESET);
  cov_top_write: cover property (q.wr.en && q.wr.addr == twr_pkg::PTR_MAX);

endmodule : twr_port

/* dv/twr_host.sv */
// Bus master model that drives the serial clock and data pins of the port.
`timescale 1ns/1ns
module twr_host (
  input wire logic clock_i,
  input wire logic sda_wire_i,
  output logic scl_o,
  output logic sda_o
);

  // The clock idles high and data is released (pulled up) outside frames.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick

  // ----------------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------------
  task automatic start();
    sda_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
    tick(2);
  endtask : start

  task automatic stop();
    sda_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b1;
    tick(8);
  endtask : stop

  // One bus clock of 80 ns: data set mid-low, sampled mid-high.
  task automatic bit_xfer(input logic b, output logic r);
    sda_o <= b;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    r = sda_wire_i;
    tick(2);
    scl_o <= 1'b0;
    tick(2);
  endtask : bit_xfer

  // ----------------------------------------------------------------------
  // Bytes, most significant bit first
  // ----------------------------------------------------------------------
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, ack);
  endtask : byte_w

  task automatic byte_r(output logic [7:0] d, input logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(ack_n, r);
  endtask : byte_r

endmodule : twr_host

/* dv/twr_port_test.sv */
// Self-checking testbench of the two-wire register access port.
`timescale 1ns/1ns
module twr_port_test;

  localparam logic [6:0] DEV = 7'h0E;

  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] strap = 4'hE;
  logic host_scl;
  logic host_sda;
  logic dut_sda;
  logic dut_oe_n;
  logic [6:0] slave_addr;
  twr_pkg::twr_wr_s reg_wr;
  wire sda_wire = host_sda & (dut_oe_n | dut_sda);
  twr_pkg::twr_wr_s wq[$];
  int n_mismatch = 0;
  int samples_checked = 0;

  always #5 clock_i = ~clock_i;

  twr_port twr_port_i (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .primary_serial_clock_i(host_scl),
    .primary_serial_data_i(sda_wire),
    .addr_strap_i(strap),
    .primary_serial_data_o(dut_sda),
    .primary_serial_data_oe_n_o(dut_oe_n),
    .slave_addr_o(slave_addr),
    .reg_wr_o(reg_wr)
  );

  twr_host twr_host_i (
    .clock_i(clock_i),
    .sda_wire_i(sda_wire),
    .scl_o(host_scl),
    .sda_o(host_sda)
  );

  always @(posedge clock_i) begin
    if (reg_wr.en === 1'b1) begin
      wq.push_back(reg_wr);
    end
  end

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic send(input logic [7:0] b);
    logic a;
    twr_host_i.byte_w(b, a);
    check({7'h00, a}, 8'h00);
  endtask : send

  task automatic expect_wr(input logic [7:0] a, input logic [7:0] d);
    twr_pkg::twr_wr_s w;
    w = '0;
    if (wq.size() != 0) begin
      w = wq.pop_front();
    end
    check({7'h00, w.en}, 8'h01);
    check({1'b0, w.addr}, a);
    check(w.data, d);
  endtask : expect_wr

  task automatic fetch(input logic [7:0] exp, input logic ack_n);
    logic [7:0] d;
    twr_host_i.byte_r(d, ack_n);
    check(d, exp);
  endtask : fetch

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_strap();
    check({1'b0, slave_addr}, 8'h0E);
    strap <= 4'h5;
    repeat (10) @(posedge clock_i);
    check({1'b0, slave_addr}, 8'h0E);
  endtask : test_strap

  task automatic test_write_read();
    twr_host_i.start();
    send({DEV, 1'b0});
    send(8'h05);
    send(8'hA1);
    send(8'hB2);
    send(8'hC3);
    twr_host_i.stop();
    expect_wr(8'h05, 8'hA1);
    expect_wr(8'h06, 8'hB2);
    expect_wr(8'h07, 8'hC3);
    twr_host_i.start();
    send({DEV, 1'b0});
    send(8'h05);
    twr_host_i.start();
    send({DEV, 1'b1});
    fetch(8'hA1, 1'b0);
    fetch(8'hB2, 1'b0);
    fetch(8'hC3, 1'b1);
    // Give the port time to see the last clock fall; it must not start another byte.
    repeat (4) @(posedge clock_i);
    check({7'h00, dut_oe_n}, 8'h01);
    twr_host_i.stop();
  endtask : test_write_read

  task automatic test_stop_read();
    twr_host_i.start();
    send({DEV, 1'b0});
    send(8'h00);
    send(8'h5A);
    twr_host_i.stop();
    expect_wr(8'h00, 8'h5A);
    twr_host_i.start();
    send({DEV, 1'b0});
    send(8'h06);
    twr_host_i.stop();
    twr_host_i.start();
    send({DEV, 1'b1});
    fetch(8'h5A, 1'b1);
    twr_host_i.stop();
  endtask : test_stop_read

  task automatic test_hold();
    twr_host_i.start();
    send({DEV, 1'b0});
    send(8'h90);
    send(8'h11);
    send(8'h22);
    twr_host_i.stop();
    expect_wr(8'h10, 8'h11);
    expect_wr(8'h10, 8'h22);
  endtask : test_hold

  task automatic test_saturate();
    twr_host_i.start();
    send({DEV, 1'b0});
    send(8'h7E);
    send(8'h31);
    send(8'h32);
    send(8'h33);
    twr_host_i.stop();
    expect_wr(8'h7E, 8'h31);
    expect_wr(8'h7F, 8'h32);
    expect_wr(8'h7F, 8'h33);
  endtask : test_saturate

  task automatic test_foreign();
    logic a;
    twr_host_i.start();
    twr_host_i.byte_w({7'h0F, 1'b0}, a);
    check({7'h00, a}, 8'h01);
    twr_host_i.byte_w(8'h20, a);
    twr_host_i.byte_w(8'h44, a);
    check({7'h00, a}, 8'h01);
    twr_host_i.stop();
    check(8'(wq.size()), 8'h00);
  endtask : test_foreign

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    test_strap();
    test_write_read();
    test_stop_read();
    test_hold();
    test_saturate();
    test_foreign();
    results();
  end

  // The scenarios need about 24 us; allow a wide margin before giving up.
  initial begin
    #400000;
    n_mismatch++;
    results();
  end

endmodule : twr_port_test
